// ---- common/nand_host_pkg.sv ----
package nand_host_pkg;
  // Command codes
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_RAND_OUT = 8'h05;
  localparam logic [7:0] CMD_RAND_OUT_CONFIRM = 8'he0;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
  localparam logic [7:0] CMD_RAND_IN = 8'h85;
  localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_PROG_DUMMY = 8'h11;
  localparam logic [7:0] CMD_PROG_SECOND = 8'h81;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
  localparam logic [7:0] CMD_RESET = 8'hff;
  // Status bit positions
  localparam int READY_STATUS_BIT = 6;
  localparam int PASS_FAIL_BIT = 0;
  // Address cycle counts
  localparam logic [2:0] ADDR_CYC_FULL = 3'd5;
  localparam logic [2:0] ADDR_CYC_COL = 3'd2;
  localparam logic [2:0] ADDR_CYC_BLOCK = 3'd3;
  localparam logic [2:0] ADDR_CYC_STATUS = 3'd3;
  // Plane select bit position within the third address byte
  localparam int PLANE_SEL_BIT = 6;
  // Bus timing: strobe phases at 40 MHz
  localparam int CLK_NS = 25;
  localparam int PHASE_NS = 25;
  localparam logic [3:0] PHASE_CYC = 4'((PHASE_NS + CLK_NS - 1) / CLK_NS);
  // Operation codes on the user port
  typedef enum logic [2:0] {
    OP_READ = 3'b000,
    OP_PROG = 3'b001,
    OP_PROG2 = 3'b010,
    OP_ERASE = 3'b011,
    OP_STATUS = 3'b100,
    OP_RESET = 3'b101,
    OP_RAND_OUT = 3'b110,
    OP_RAND_IN = 3'b111
  } op_t;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 16;
endpackage

// ---- rtl/nand_host_ctrl.sv ----
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module byte_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic wr;
  logic rd;
  assign in_ready_o = (cnt_r != (AW+1)'(D));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem[rp_r];
  assign wr = in_valid_i && in_ready_o;
  assign rd = out_valid_o && out_ready_i;
  always_ff @(posedge mclk_i) begin
    if (wr) begin
      mem[wp_r] <= in_data_i;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (wr) begin
        wp_r <= wp_r + 1'b1;
      end
      if (rd) begin
        rp_r <= rp_r + 1'b1;
      end
      if (wr && !rd) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (rd && !wr) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule
////////////////////////////////////////////////////////////////////////////////
module nand_host_ctrl
  import nand_host_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  // User request
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire nand_host_pkg::op_t req_op_i,
  input wire logic [39:0] req_addr_i,
  input wire logic [12:0] req_len_i,
  input wire logic req_wp_n_i,
  // Write data in
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [7:0] wr_data_i,
  // Read data out
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  // Completion
  output logic done_o,
  output logic [7:0] status_o,
  // Flash pins
  output logic ce_n_o,
  output logic cle_o,
  output logic ale_o,
  output logic we_n_o,
  output logic re_n_o,
  output logic wp_n_o,
  input wire logic rb_n_i,
  input wire logic [7:0] io_i,
  output logic [7:0] io_o,
  output logic io_oe_o
);
  import nand_host_pkg::*;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_CMD1 = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_DIN = 4'b0011,
    ST_CMD2 = 4'b0100,
    ST_BUSY = 4'b0101,
    ST_DOUT = 4'b0110,
    ST_CMD3 = 4'b0111,
    ST_STAT = 4'b1000,
    ST_DONE = 4'b1001
  } st_t;
  st_t st_r;
  op_t op_r;
  logic [39:0] addr_r;
  logic [12:0] len_r;
  logic [12:0] plen_r;
  logic [2:0] acnt_r;
  logic [2:0] alim_r;
  logic [3:0] ph_r;
  logic half_r;
  logic second_r;
  logic busy_seen_r;
  logic [7:0] c1;
  logic [7:0] c2;
  logic strobe_end;
  logic f_valid;
  logic f_ready;
  logic [7:0] f_data;
  logic take_byte;
  //////////////////////////////////////////////////////////////////////////////
  // Write data buffer
  byte_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .in_valid_i(wr_valid_i),
    .in_ready_o(wr_ready_o),
    .in_data_i(wr_data_i),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready),
    .out_data_o(f_data)
  );
  assign req_ready_o = (st_r == ST_IDLE);
  // Each bus cycle: low half then high half, each PHASE_CYC cycles
  assign strobe_end = half_r && (ph_r == PHASE_CYC - 4'd1);
  assign take_byte = (st_r == ST_DIN) && f_valid && !half_r && (ph_r == 4'd0);
  assign f_ready = take_byte;
  always_comb begin
    c1 = CMD_READ_SETUP;
    c2 = CMD_READ_CONFIRM;
    case (op_r)
      OP_READ: begin
        c1 = CMD_READ_SETUP;
        c2 = CMD_READ_CONFIRM;
      end
      OP_PROG, OP_PROG2: begin
        c1 = second_r ? CMD_PROG_SECOND : CMD_PROG_SETUP;
        c2 = (op_r == OP_PROG2 && !second_r) ? CMD_PROG_DUMMY : CMD_PROG_CONFIRM;
      end
      OP_ERASE: begin
        c1 = CMD_ERASE_SETUP;
        c2 = CMD_ERASE_CONFIRM;
      end
      OP_STATUS: c1 = CMD_STATUS;
      OP_RESET: c1 = CMD_RESET;
      OP_RAND_OUT: begin
        c1 = CMD_RAND_OUT;
        c2 = CMD_RAND_OUT_CONFIRM;
      end
      OP_RAND_IN: c1 = CMD_RAND_IN;
      default: c1 = CMD_RESET;
    endcase
  end
  //////////////////////////////////////////////////////////////////////////////
  // Strobe phase counter
  always_ff @(posedge mclk_i) begin
    if (rst_i || st_r == ST_IDLE || st_r == ST_BUSY || st_r == ST_DONE) begin
      ph_r <= '0;
      half_r <= 1'b0;
    end else if (st_r == ST_DIN && !half_r && ph_r == 4'd0 && !f_valid) begin
      ph_r <= '0;
    end else if (ph_r == PHASE_CYC - 4'd1) begin
      ph_r <= '0;
      half_r <= !half_r;
    end else begin
      ph_r <= ph_r + 4'd1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_r <= ST_IDLE;
      op_r <= OP_RESET;
      addr_r <= '0;
      len_r <= '0;
      plen_r <= '0;
      acnt_r <= '0;
      alim_r <= '0;
      second_r <= 1'b0;
      busy_seen_r <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (req_valid_i) begin
            op_r <= req_op_i;
            addr_r <= req_addr_i;
            if (req_op_i == OP_PROG2) begin
              addr_r[16+PLANE_SEL_BIT] <= 1'b0;
            end
            len_r <= req_len_i;
            plen_r <= req_len_i;
            second_r <= 1'b0;
            // Erase sends only the three row bytes
            acnt_r <= (req_op_i == OP_ERASE) ? ADDR_CYC_FULL - ADDR_CYC_BLOCK : 3'd0;
            case (req_op_i)
              OP_RAND_OUT, OP_RAND_IN: alim_r <= ADDR_CYC_COL;
              OP_ERASE: alim_r <= ADDR_CYC_FULL;
              OP_STATUS, OP_RESET: alim_r <= '0;
              default: alim_r <= ADDR_CYC_FULL;
            endcase
            st_r <= ST_CMD1;
          end
        end
        ST_CMD1: begin
          if (strobe_end) begin
            st_r <= (alim_r == '0) ? ((op_r == OP_RESET) ? ST_BUSY : ST_STAT) : ST_ADDR;
            busy_seen_r <= 1'b0;
          end
        end
        ST_ADDR: begin
          if (strobe_end) begin
            acnt_r <= acnt_r + 3'd1;
            if (acnt_r == alim_r - 3'd1) begin
              case (op_r)
                OP_PROG, OP_PROG2, OP_RAND_IN: st_r <= (len_r == '0) ? ST_CMD2 : ST_DIN;
                OP_RAND_OUT: st_r <= ST_CMD2;
                default: st_r <= ST_CMD2;
              endcase
            end
          end
        end
        ST_DIN: begin
          if (strobe_end) begin
            len_r <= len_r - 13'd1;
            if (len_r == 13'd1) begin
              // Random input ends without a confirm; load continues later
              st_r <= (op_r == OP_RAND_IN) ? ST_DONE : ST_CMD2;
            end
          end
        end
        ST_CMD2: begin
          if (strobe_end) begin
            busy_seen_r <= 1'b0;
            st_r <= (op_r == OP_RAND_OUT) ? ST_DOUT : ST_BUSY;
          end
        end
        ST_BUSY: begin
          // Wait ready/busy low then high; no command issued meanwhile
          if (!rb_n_i) begin
            busy_seen_r <= 1'b1;
          end
          if (busy_seen_r && rb_n_i) begin
            if (op_r == OP_PROG2 && !second_r) begin
              second_r <= 1'b1;
              addr_r[16+PLANE_SEL_BIT] <= 1'b1;
              acnt_r <= '0;
              len_r <= plen_r;
              st_r <= ST_CMD1;
            end else if (op_r == OP_READ) begin
              st_r <= (len_r == '0) ? ST_DONE : ST_DOUT;
            end else if (op_r == OP_RESET) begin
              st_r <= ST_DONE;
            end else begin
              st_r <= ST_CMD3;
            end
          end
        end
        ST_CMD3: begin
          if (strobe_end) begin
            st_r <= ST_STAT;
          end
        end
        ST_DOUT: begin
          if (strobe_end) begin
            len_r <= len_r - 13'd1;
            if (len_r == 13'd1) begin
              st_r <= ST_DONE;
            end
          end
        end
        ST_STAT: begin
          if (strobe_end) begin
            st_r <= ST_DONE;
          end
        end
        ST_DONE: st_r <= ST_IDLE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Pins
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ce_n_o <= 1'b1;
      cle_o <= 1'b0;
      ale_o <= 1'b0;
      we_n_o <= 1'b1;
      re_n_o <= 1'b1;
      io_o <= '0;
      io_oe_o <= 1'b0;
    end else begin
      ce_n_o <= (st_r == ST_IDLE || st_r == ST_DONE);
      cle_o <= (st_r == ST_CMD1 || st_r == ST_CMD2 || st_r == ST_CMD3);
      ale_o <= (st_r == ST_ADDR);
      we_n_o <= !((st_r == ST_CMD1 || st_r == ST_CMD2 || st_r == ST_CMD3 ||
                  st_r == ST_ADDR || (st_r == ST_DIN && (half_r || f_valid))) && !half_r);
      re_n_o <= !((st_r == ST_DOUT || st_r == ST_STAT) && !half_r);
      io_oe_o <= (st_r == ST_CMD1 || st_r == ST_CMD2 || st_r == ST_CMD3 ||
                  st_r == ST_ADDR || st_r == ST_DIN);
      if (take_byte) begin
        io_o <= f_data;
      end else if (st_r == ST_CMD1) begin
        io_o <= c1;
      end else if (st_r == ST_CMD2) begin
        io_o <= c2;
      end else if (st_r == ST_CMD3) begin
        io_o <= CMD_STATUS;
      end else if (st_r == ST_ADDR) begin
        io_o <= addr_r[8*acnt_r +: 8];
      end
    end
  end
  assign wp_n_o = req_wp_n_i;
  //////////////////////////////////////////////////////////////////////////////
  // Captured output
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o <= '0;
      status_o <= '0;
      done_o <= 1'b0;
    end else begin
      rd_valid_o <= 1'b0;
      done_o <= (st_r == ST_DONE);
      if (strobe_end && st_r == ST_DOUT) begin
        rd_valid_o <= 1'b1;
        rd_data_o <= io_i;
      end
      if (strobe_end && st_r == ST_STAT) begin
        status_o <= io_i;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Checks
  a_busy_no_cmd: assert property (@(posedge mclk_i) disable iff (rst_i)
    (st_r == ST_BUSY) |=> !cle_o)
    else $error("command strobed while waiting busy");
  a_idle_ce_high: assert property (@(posedge mclk_i) disable iff (rst_i)
    (st_r == ST_IDLE) |=> ce_n_o)
    else $error("chip enable low while idle");
  a_read_latches: assert property (@(posedge mclk_i) disable iff (rst_i)
    !re_n_o |-> (!cle_o && !ale_o && we_n_o && !ce_n_o))
    else $error("read strobe with bad latch state");
  a_second_plane: assert property (@(posedge mclk_i) disable iff (rst_i)
    (st_r == ST_CMD1 && second_r && op_r == OP_PROG2) |-> addr_r[16+PLANE_SEL_BIT])
    else $error("second plane address not in plane one");
  a_erase_cmd: assert property (@(posedge mclk_i) disable iff (rst_i)
    (st_r == ST_CMD2 && op_r == OP_ERASE && half_r) |-> (cle_o && io_o == CMD_ERASE_CONFIRM))
    else $error("erase confirm wrong");
  a_busy_wait: assert property (@(posedge mclk_i) disable iff (rst_i)
    (st_r == ST_BUSY && !busy_seen_r && rb_n_i) |=> (st_r == ST_BUSY))
    else $error("left busy wait before busy seen");
  a_rd_pulse: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_valid_o |=> !rd_valid_o)
    else $error("read valid longer than one cycle");
  a_oe_read: assert property (@(posedge mclk_i) disable iff (rst_i)
    !re_n_o |-> !io_oe_o)
    else $error("driving bus during read");
endmodule

// ---- tb/nand_dev_model.sv ----
`timescale 1ns/100ps
module nand_dev_model (
  // Pins from host
  input wire logic ce_n_i,
  input wire logic cle_i,
  input wire logic ale_i,
  input wire logic we_n_i,
  input wire logic re_n_i,
  input wire logic wp_n_i,
  input wire logic [7:0] io_i,
  // Pins to host
  output logic [7:0] io_o,
  output logic rb_n_o,
  // Bench knobs
  input wire logic [31:0] busy_ns_i,
  input wire logic fail_i
);
  logic [7:0] mem [128];
  logic [7:0] pbuf [128];
  logic [7:0] cmd_r;
  logic [6:0] col_r;
  logic fail_r;
  logic smode_r;
  int acnt_r;

  task automatic go_busy(input int ns);
    rb_n_o = 1'h0;
    #(ns);
    rb_n_o = 1'h1;
  endtask

  task automatic kick(input int ns);
    fork
      go_busy(ns);
    join_none
  endtask

  initial begin
    rb_n_o = 1'h1;
    io_o = 8'h00;
    fail_r = 1'h0;
    smode_r = 1'h0;
    acnt_r = 0;
    cmd_r = 8'h00;
    col_r = 7'h00;
    foreach (mem[i]) begin
      mem[i] = 8'hff;
      pbuf[i] = 8'hff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protection setup sequences are not decoded
  always @(posedge we_n_i) begin
    if (!ce_n_i && cle_i) begin
      cmd_r = io_i;
      acnt_r = 0;
      smode_r = (io_i == 8'h70) || (io_i == 8'h78);
      if (io_i == 8'h30 || io_i == 8'hff) kick(busy_ns_i);
      if (io_i == 8'h11) kick(250);
      if (io_i == 8'h10 || io_i == 8'hd0) begin
        fail_r = fail_i;
        if (wp_n_i) begin
          foreach (mem[i]) begin
            mem[i] = (io_i == 8'hd0) ? 8'hff : mem[i] & pbuf[i];
            pbuf[i] = 8'hff;
          end
        end
        kick(busy_ns_i);
      end
    end else if (!ce_n_i && ale_i) begin
      if (acnt_r == 0) col_r[5:0] = io_i[5:0];
      if (acnt_r == 2 && cmd_r != 8'h60) col_r[6] = io_i[6];
      acnt_r++;
    end else if (!ce_n_i) begin
      pbuf[col_r] = io_i;
      col_r[5:0] = col_r[5:0] + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(negedge re_n_i) begin
    if (!ce_n_i) begin
      if (smode_r) begin
        io_o = {1'h0, rb_n_o, 5'h00, fail_r};
      end else begin
        io_o = mem[col_r];
        col_r[5:0] = col_r[5:0] + 6'h01;
      end
    end
  end

  // Released bus shows the inverse of the last byte
  always @(posedge re_n_i or posedge ce_n_i) io_o = ~io_o;
endmodule

// ---- tb/nand_host_ctrl_tb_top.sv ----
`timescale 1ns/100ps
module nand_host_ctrl_tb_top;
  import nand_host_pkg::*;
  logic mclk_i = 1'h0;
  logic rst_i = 1'h1;
  logic req_valid_i = 1'h0;
  logic req_ready_o;
  op_t req_op_i = OP_STATUS;
  logic [39:0] req_addr_i = '0;
  logic [12:0] req_len_i = '0;
  logic req_wp_n_i = 1'h1;
  logic wr_valid_i = 1'h0;
  logic wr_ready_o;
  logic [7:0] wr_data_i = 8'h00;
  logic rd_valid_o, done_o, ce_n_o, cle_o, ale_o, we_n_o, re_n_o, wp_n_o, rb_n_i, io_oe_o;
  logic [7:0] rd_data_o, status_o, io_i, io_o, dev_io;
  logic fail_i = 1'h0;
  int busy_ns = 300;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int refm [128];
  logic [7:0] wdq [$];
  logic [7:0] rdq [$];

  always #12.5 mclk_i = ~mclk_i;
  assign io_i = io_oe_o ? io_o : dev_io;

  nand_host_ctrl dut (
    .mclk_i(mclk_i), .rst_i(rst_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_op_i(req_op_i),
    .req_addr_i(req_addr_i), .req_len_i(req_len_i), .req_wp_n_i(req_wp_n_i),
    .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o), .wr_data_i(wr_data_i),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .done_o(done_o), .status_o(status_o),
    .ce_n_o(ce_n_o), .cle_o(cle_o), .ale_o(ale_o), .we_n_o(we_n_o), .re_n_o(re_n_o),
    .wp_n_o(wp_n_o), .rb_n_i(rb_n_i), .io_i(io_i), .io_o(io_o), .io_oe_o(io_oe_o)
  );

  nand_dev_model dev (
    .ce_n_i(ce_n_o), .cle_i(cle_o), .ale_i(ale_o), .we_n_i(we_n_o), .re_n_i(re_n_o),
    .wp_n_i(wp_n_o), .io_i(io_i), .io_o(dev_io), .rb_n_o(rb_n_i),
    .busy_ns_i(busy_ns), .fail_i(fail_i)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic flag(input string m);
    error_cnt++;
    $display("mismatch t=%0t %s", $time, m);
  endtask

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      flag("timeout");
      close_out();
    end
  end

  // Write data feeder and read data collector
  always @(posedge mclk_i) begin
    if (rd_valid_o === 1'h1) rdq.push_back(rd_data_o);
    if (wr_valid_i && wr_ready_o === 1'h1) void'(wdq.pop_front());
    #2;
    wr_valid_i = (wdq.size() > 0);
    if (wdq.size() > 0) wr_data_i = wdq[0];
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [39:0] mk(input int c, input int p);
    return {16'h0000, 1'h0, p[0], 6'h05, 8'h00, 2'h0, c[5:0]};
  endfunction

  task automatic load(input int c, input int p, input int n);
    logic [7:0] d;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      wdq.push_back(d);
      refm[p * 64 + (c + i) % 64] &= d;
    end
  endtask

  task automatic run(input op_t op, input logic [39:0] a, input int n);
    req_op_i = op;
    req_addr_i = a;
    req_len_i = 13'(n);
    req_valid_i = 1'h1;
    @(posedge mclk_i);
    while (req_ready_o !== 1'h1) @(posedge mclk_i);
    #2 req_valid_i = 1'h0;
    rdq.delete();
    @(posedge mclk_i);
    while (done_o !== 1'h1) @(posedge mclk_i);
    #2;
  endtask

  task automatic cmp_stat(input logic [7:0] e);
    tests_run++;
    if (status_o !== e) flag($sformatf("status %h exp %h", status_o, e));
  endtask

  task automatic chk_read(input int c, input int p, input int n);
    logic [7:0] e;
    tests_run++;
    if (rdq.size() != n) flag($sformatf("read count %0d exp %0d", rdq.size(), n));
    for (int i = 0; i < n && i < rdq.size(); i++) begin
      e = 8'(refm[p * 64 + (c + i) % 64]);
      tests_run++;
      if (rdq[i] !== e) flag($sformatf("byte %0d got %h exp %h", i, rdq[i], e));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int c, n;
    void'($urandom(87579));
    foreach (refm[i]) refm[i] = 255;
    repeat (12) @(posedge mclk_i);
    #2 rst_i = 1'h0;
    run(OP_RESET, '0, 0);
    run(OP_ERASE, mk(0, 0), 0);
    cmp_stat(8'h40);
    for (int t = 0; t < 3; t++) begin
      c = $urandom_range(40);
      n = $urandom_range(24, 17);
      busy_ns = $urandom_range(3000, 250);
      fail_i = 1'(t == 2);
      load(c, 0, n);
      run(OP_PROG, mk(c, 0), n);
      cmp_stat({1'h0, 1'h1, 5'h00, fail_i});
      run(OP_READ, mk(c, 0), n);
      chk_read(c, 0, n);
      for (int r = 0; r < 2; r++) begin
        run(OP_RAND_OUT, mk(c + 5 * r, 0), 4);
        chk_read(c + 5 * r, 0, 4);
      end
    end
    fail_i = 1'h0;
    load(50, 0, 3);
    run(OP_RAND_IN, mk(50, 0), 3);
    load(60, 0, 2);
    run(OP_PROG, mk(60, 0), 2);
    run(OP_READ, mk(50, 0), 12);
    chk_read(50, 0, 12);
    c = $urandom_range(30);
    load(c, 0, 20);
    load(c, 1, 20);
    run(OP_PROG2, mk(c, 0), 20);
    cmp_stat(8'h40);
    for (int p = 0; p < 2; p++) begin
      run(OP_READ, mk(c, p), 20);
      chk_read(c, p, 20);
    end
    run(OP_STATUS, '0, 0);
    cmp_stat(8'h40);
    req_wp_n_i = 1'h0;
    repeat (4) wdq.push_back(8'($urandom));
    run(OP_PROG, mk(8, 1), 4);
    cmp_stat(8'h40);
    req_wp_n_i = 1'h1;
    run(OP_READ, mk(8, 1), 4);
    chk_read(8, 1, 4);
    run(OP_ERASE, mk(0, 1), 0);
    foreach (refm[i]) refm[i] = 255;
    run(OP_READ, mk(0, 1), 8);
    chk_read(0, 1, 8);
    close_out();
  end
endmodule
